// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import wes_pkg::*;

  logic                           clk_i;
  logic                           rst_b_i;
  wes_reg_req_t                   reg_req_i;
  logic [DATA_W-1:0]              rd_data_o;
  wes_wake_src_t                  wake_src_i;
  logic [NUM_GRP-1:0][DATA_W-1:0] wake_src_en_i;
  logic                           pin_n;
  logic                           pin_oe;
  logic                           line_n;
  logic                           seen;
  int                             err_total;
  int                             checks;
  int                             idx;
  localparam int                  CORNER_IDX [6] = '{22, 8, 7, 10, 14, 15};

  wes_wake_status_bank dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_req_i(reg_req_i),
    .rd_data_o(rd_data_o), .wake_src_i(wake_src_i), .wake_src_en_i(wake_src_en_i),
    .wake_event_out_n_o(pin_n), .wake_event_oe_o(pin_oe));

  wes_sys_wake_model sys_u (.clk_i(clk_i), .pin_val_i(pin_n), .pin_oe_i(pin_oe),
    .line_n_o(line_n), .wake_seen_o(seen));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD at %0t: %s seen %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_req_i = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(negedge clk_i);
    reg_req_i = '0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string msg);
    @(negedge clk_i);
    reg_req_i = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_i);
    reg_req_i = '0;
    chk(rd_data_o, exp, msg);
  endtask : rd

  task automatic pulse(input int i);
    @(negedge clk_i);
    wake_src_i[i] = 1'b1;
    repeat (2) @(negedge clk_i);
    wake_src_i[i] = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask : pulse

  function automatic logic [3:0] reg_of(input int i);
    return (i < 8) ? OFF_STS_G1 : ((i < 15) ? OFF_STS_G2 : OFF_STS_G3);
  endfunction : reg_of

  function automatic logic [7:0] bit_of(input int i);
    return 8'h01 << ((i < 8) ? i : ((i < 15) ? i - 8 : i - 15));
  endfunction : bit_of

  task automatic final_report();
    $display("Checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial begin
    #(50 * 5000);
    err_total++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    err_total = 0;
    checks = 0;
    rst_b_i = 1'b0;
    reg_req_i = '0;
    wake_src_i = '0;
    wake_src_en_i = '0;
    void'($urandom(32'h188e));
    repeat (3) @(negedge clk_i);
    rst_b_i = 1'b1;
    for (int a = 0; a < 6; a++) begin
      rd(a[3:0], 8'h00, "reset value");
    end
    wr(OFF_GLOB_EN, 8'hff);
    rd(OFF_GLOB_EN, 8'h01, "enable reserved bits");
    wr(OFF_GLOB_EN, 8'h00);
    $display("test reset and reserved done");
    for (int n = 0; n < 14; n++) begin
      idx = (n < 6) ? CORNER_IDX[n] : int'($urandom % 23);
      wake_src_en_i = SRC_W'($urandom);
      pulse(idx);
      rd(reg_of(idx), bit_of(idx), "event sets bit");
      wr(reg_of(idx), 8'h00);
      rd(reg_of(idx), bit_of(idx), "zero write");
      wr(reg_of(idx), bit_of(idx) | 8'h80);
      rd(reg_of(idx), 8'h00, "one write clears");
    end
    chk({7'h0, line_n}, 8'h01, "line idle with enable off");
    wake_src_en_i = '0;
    wr(OFF_GLOB_STS, 8'h01);
    $display("test source mapping done");
    wr(OFF_GLOB_EN, 8'h01);
    pulse(9);
    chk({7'h0, line_n}, 8'h01, "no drive without source enable");
    wr(OFF_STS_G2, 8'h02);
    wake_src_en_i[0] = 8'h01;
    pulse(0);
    rd(OFF_GLOB_STS, 8'h01, "global status set");
    chk({6'h00, line_n, seen}, 8'h01, "wake line asserted");
    wr(OFF_GLOB_EN, 8'h00);
    chk({7'h0, line_n}, 8'h01, "suppressed by enable");
    rd(OFF_GLOB_STS, 8'h01, "status independent of enable");
    wr(OFF_GLOB_EN, 8'h01);
    wr(OFF_STS_G1, 8'h01);
    wr(OFF_GLOB_STS, 8'h00);
    rd(OFF_GLOB_STS, 8'h01, "zero write to global");
    chk({7'h0, line_n}, 8'h00, "wake line held with no source left");
    wr(OFF_GLOB_STS, 8'h01);
    rd(OFF_GLOB_STS, 8'h00, "global cleared");
    chk({7'h0, line_n}, 8'h01, "wake line released");
    $display("test global enable and status done");
    @(negedge clk_i);
    wake_src_i.g3[5] = 1'b1;
    @(negedge clk_i);
    wr(OFF_STS_G3, 8'h20);
    wake_src_i.g3[5] = 1'b0;
    rd(OFF_STS_G3, 8'h20, "event beats same-cycle clear");
    $display("test event against clear done");
    pulse(16);
    @(negedge clk_i);
    rst_b_i = 1'b0;
    @(negedge clk_i);
    rst_b_i = 1'b1;
    rd(OFF_STS_G3, 8'h00, "standby reset clears status");
    rd(OFF_GLOB_EN, 8'h00, "standby reset clears enable");
    $display("test standby reset done");
    final_report();
  end

endmodule : tb_top

`default_nettype wire

// >>> wes_pkg.sv
`default_nettype none

package wes_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned NUM_GRP = 3;
  localparam int unsigned SRC_W   = NUM_GRP * DATA_W;

  // ----------------------------------------------------------------
  // Register offsets inside the runtime block
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_GLOB_STS = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_GLOB_EN  = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_STS_G1   = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_STS_G2   = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_STS_G3   = 4'h4;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned         GLOB_BIT      = 0;
  localparam int unsigned         G2_INDEX      = 1;
  localparam logic [DATA_W-1:0]   STS_RESET     = 8'h00;
  localparam logic [DATA_W-1:0]   ALL_ZERO      = 8'h00;
  localparam logic [DATA_W-1:0]   ALL_ONES      = 8'hff;
  localparam logic [DATA_W-1:0]   G2_VALID_MASK = 8'h7f;
  localparam logic                BIT_RESET     = 1'b0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              wr_en;
    logic              rd_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } wes_reg_req_t;

  typedef struct packed {
    logic [7:0] g3;
    logic [4:0] g2;
    logic [1:0] ring;
    logic [7:0] g1;
  } wes_wake_src_t;

  // ----------------------------------------------------------------
  // Write-one-to-clear update, a new event wins over the clear
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] w1c_next(input logic [DATA_W-1:0] cur,
                                                 input logic [DATA_W-1:0] clr,
                                                 input logic [DATA_W-1:0] evt);
    w1c_next = (cur & ~clr) | evt;
  endfunction : w1c_next

endpackage : wes_pkg

`default_nettype wire

// >>> wes_sys_wake_model.sv
`timescale 1ns/100ps
`default_nettype none

module wes_sys_wake_model (
  // Clock
  input  wire logic clk_i,
  // Open-drain pin drive from the device
  input  wire logic pin_val_i,
  input  wire logic pin_oe_i,
  // Resolved line and system-side sample
  output logic      line_n_o,
  output logic      wake_seen_o
);
  // ----------------------------------------------------------------
  // Pull-up keeps the line high whenever nobody pulls it down
  // ----------------------------------------------------------------
  assign line_n_o = pin_oe_i ? pin_val_i : 1'b1;

  always_ff @(posedge clk_i) begin
    wake_seen_o <= ~line_n_o;
  end

endmodule : wes_sys_wake_model

`default_nettype wire

// >>> wes_wake_status_bank.sv
// Operation
// (RULE1) Global enable bit 0 high lets the wake output assert; low suppresses it.
// (RULE2) Global enable bits 7..1 are reserved with no function.
// (RULE3) Global enable survives main, soft and hard resets; standby reset clears it.
// (RULE4) Status bits record events regardless of per-source and global enables.
// (RULE5) A wake event sets its status bit, held until software clears it.
// (RULE6) First status register holds group-one pins 0..7 on bits 0..7.
// (RULE7) Second: ring one bit 0, ring two bit 1, group-two 0..4 bits 2..6.
// (RULE8) Third status register holds group-three pins 0..7 on bits 0..7.
// (RULE9) Status registers survive main, soft, hard resets; standby reset gives 0x00.
// (RULE10) Writing 1 to a status bit clears it.
// (RULE11) Writing 0 to a status bit leaves it unchanged.
// (RULE12) Global status sets when any status bit and its enable are both high.
// (RULE13) Writing 1 to global status clears it and stops the output; 0 does nothing.
// (RULE14) Reserved bits read back as 0.
// (RULE15) Event and clear on the same bit in one cycle leave the bit set.
`timescale 1ns/100ps
`default_nettype none

module wes_wake_status_bank
  import wes_pkg::*;
(
  // Clock and standby-rail reset
  input  wire  logic                             clk_i,
  input  wire  logic                             rst_b_i,
  // Register port
  input  wire  wes_reg_req_t                     reg_req_i,
  output logic [DATA_W-1:0]                      rd_data_o,
  // Wake sources and per-source enables
  input  wire  wes_wake_src_t                    wake_src_i,
  input  wire  logic [NUM_GRP-1:0][DATA_W-1:0]   wake_src_en_i,
  // Open-drain wake output
  output logic                                   wake_event_out_n_o,
  output logic                                   wake_event_oe_o
);

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  function automatic logic sts_hit(input logic [ADDR_W-1:0] addr, input int unsigned g);
    sts_hit = (addr == (OFF_STS_G1 + ADDR_W'(g)));
  endfunction : sts_hit

  function automatic logic [DATA_W-1:0] grp_valid(input int unsigned g);
    grp_valid = (g == G2_INDEX) ? G2_VALID_MASK : ALL_ONES;
  endfunction : grp_valid

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] wake_sts [NUM_GRP];
  logic              glob_sts;
  logic              glob_en;
  logic              next_glob_sts;
  logic              next_glob_en;
  logic              pending;
  logic [SRC_W-1:0]  src_vec;
  logic [SRC_W-1:0]  src_meta;
  logic [SRC_W-1:0]  src_sync;
  logic [SRC_W-1:0]  src_prev;
  logic [SRC_W-1:0]  evt_vec;
  logic [DATA_W-1:0] next_rd_data;
  logic              wr_glob_sts;
  logic              wr_glob_en;

  // ----------------------------------------------------------------
  // Source mapping and synchronisation
  // ----------------------------------------------------------------
  assign src_vec = {wake_src_i.g3,                                 // see RULE8
                    1'b0,                                          // see RULE7
                    wake_src_i.g2,
                    wake_src_i.ring,
                    wake_src_i.g1};                                // see RULE6

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      src_meta <= '0;
      src_sync <= '0;
      src_prev <= '0;
    end else begin
      src_meta <= src_vec;
      src_sync <= src_meta;
      src_prev <= src_sync;
    end
  end

  // Rising edge of a synchronised source is a wake event
  assign evt_vec = src_sync & ~src_prev;

  // ----------------------------------------------------------------
  // Per-source status, cleared by a written one or by the standby reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int g = 0; g < NUM_GRP; g++) begin
        wake_sts[g] <= STS_RESET;                                  // see RULE9
      end
    end else begin
      for (int g = 0; g < NUM_GRP; g++) begin
        wake_sts[g] <= w1c_next(wake_sts[g],
                                (reg_req_i.wr_en && sts_hit(reg_req_i.addr, g)) ?
                                  reg_req_i.wdata : ALL_ZERO,     // see RULE10 see RULE11
                                evt_vec[g*DATA_W +: DATA_W])       // see RULE4 see RULE5 see RULE15
                       & grp_valid(g);                             // see RULE7
      end
    end
  end

  // ----------------------------------------------------------------
  // Global status and enable
  // ----------------------------------------------------------------
  assign wr_glob_sts = reg_req_i.wr_en && (reg_req_i.addr == OFF_GLOB_STS);
  assign wr_glob_en  = reg_req_i.wr_en && (reg_req_i.addr == OFF_GLOB_EN);

  always_comb begin
    pending = 1'b0;
    for (int g = 0; g < NUM_GRP; g++) begin
      pending = pending | (|(wake_sts[g] & wake_src_en_i[g] & grp_valid(g)));  // see RULE12
    end
    next_glob_sts = (glob_sts & ~(wr_glob_sts & reg_req_i.wdata[GLOB_BIT]))
                    | pending;                                     // see RULE12 see RULE13
    next_glob_en  = wr_glob_en ? reg_req_i.wdata[GLOB_BIT] : glob_en;  // see RULE2
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      glob_sts <= BIT_RESET;
      glob_en  <= BIT_RESET;                                       // see RULE3
    end else begin
      glob_sts <= next_glob_sts;
      glob_en  <= next_glob_en;
    end
  end

  // ----------------------------------------------------------------
  // Wake output, pulled low only while enabled and global status is set
  // ----------------------------------------------------------------
  assign wake_event_out_n_o = 1'b0;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wake_event_oe_o <= BIT_RESET;
    end else begin
      wake_event_oe_o <= next_glob_en & next_glob_sts;             // see RULE1 see RULE13
    end
  end

  // ----------------------------------------------------------------
  // Read port, one cycle after the read strobe
  // ----------------------------------------------------------------
  always_comb begin
    next_rd_data = ALL_ZERO;
    case (reg_req_i.addr)
      OFF_GLOB_STS: next_rd_data[GLOB_BIT] = glob_sts;             // see RULE14
      OFF_GLOB_EN:  next_rd_data[GLOB_BIT] = glob_en;              // see RULE14
      OFF_STS_G1:   next_rd_data = wake_sts[0];
      OFF_STS_G2:   next_rd_data = wake_sts[1];
      OFF_STS_G3:   next_rd_data = wake_sts[2];
      default:      next_rd_data = ALL_ZERO;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= ALL_ZERO;
    end else if (reg_req_i.rd_en) begin
      rd_data_o <= next_rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_enable_gates_out: assert property (                           // see RULE1
    @(posedge clk_i) disable iff (!rst_b_i)
    (!next_glob_en) |=> !wake_event_oe_o
  ) else $error("wake output asserted while globally disabled");

  a_enabled_drives_out: assert property (                         // see RULE1
    @(posedge clk_i) disable iff (!rst_b_i)
    (glob_en && glob_sts && !reg_req_i.wr_en) |=> wake_event_oe_o
  ) else $error("wake output not asserted while enabled and pending");

  a_enable_reserved_zero: assert property (                       // see RULE2
    @(posedge clk_i) disable iff (!rst_b_i)
    (reg_req_i.rd_en && reg_req_i.addr == OFF_GLOB_EN) |=> (rd_data_o[DATA_W-1:1] == 7'h00)
  ) else $error("global enable reserved bits read nonzero");

  a_event_sets_bit: assert property (                             // see RULE4
    @(posedge clk_i) disable iff (!rst_b_i)
    (evt_vec[7:0] != ALL_ZERO) |=> ((wake_sts[0] & $past(evt_vec[7:0])) == $past(evt_vec[7:0]))
  ) else $error("group one event did not set its status");

  a_status_held: assert property (                                // see RULE5
    @(posedge clk_i) disable iff (!rst_b_i)
    (!reg_req_i.wr_en && wake_sts[2] != ALL_ZERO) |=>
      ((wake_sts[2] & $past(wake_sts[2])) == $past(wake_sts[2]))
  ) else $error("group three status lost without a clear");

  a_w1c_clears: assert property (                                 // see RULE10
    @(posedge clk_i) disable iff (!rst_b_i)
    (reg_req_i.wr_en && reg_req_i.addr == OFF_STS_G1 && evt_vec[7:0] == ALL_ZERO) |=>
      ((wake_sts[0] & $past(reg_req_i.wdata)) == ALL_ZERO)
  ) else $error("write one did not clear group one status");

  a_zero_write_keeps: assert property (                           // see RULE11
    @(posedge clk_i) disable iff (!rst_b_i)
    (reg_req_i.wr_en && reg_req_i.addr == OFF_STS_G3) |=>
      ((wake_sts[2] & ~$past(reg_req_i.wdata) & $past(wake_sts[2]))
        == ($past(wake_sts[2]) & ~$past(reg_req_i.wdata)))
  ) else $error("write zero changed group three status");

  a_g2_reserved_zero: assert property (                           // see RULE7
    @(posedge clk_i) disable iff (!rst_b_i)
    wake_sts[1][DATA_W-1] == 1'b0
  ) else $error("group two reserved status bit set");

  a_global_sets: assert property (                                // see RULE12
    @(posedge clk_i) disable iff (!rst_b_i)
    pending |=> glob_sts
  ) else $error("global status not set by enabled pending source");

  a_global_clears: assert property (                              // see RULE13
    @(posedge clk_i) disable iff (!rst_b_i)
    (wr_glob_sts && reg_req_i.wdata[GLOB_BIT] && !pending) |=> (!glob_sts && !wake_event_oe_o)
  ) else $error("global status clear did not release wake output");

  a_set_wins_clear: assert property (                             // see RULE15
    @(posedge clk_i) disable iff (!rst_b_i)
    (reg_req_i.wr_en && reg_req_i.addr == OFF_STS_G3 && (evt_vec[23:16] & reg_req_i.wdata) != ALL_ZERO)
      |=> ((wake_sts[2] & $past(evt_vec[23:16])) == $past(evt_vec[23:16]))
  ) else $error("event lost to a simultaneous clear");

  a_global_read_rsvd: assert property (                           // see RULE14
    @(posedge clk_i) disable iff (!rst_b_i)
    (reg_req_i.rd_en && reg_req_i.addr == OFF_GLOB_STS) |=> (rd_data_o[DATA_W-1:1] == 7'h00)
  ) else $error("global status reserved bits read nonzero");

  a_map_g1_low: assert property (                                 // see RULE6
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(wake_src_i.g1[0]) |-> ##3 wake_sts[0][0]
  ) else $error("group one pin 0 did not reach status bit 0");

  a_map_g1_high: assert property (                                // see RULE6
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(wake_src_i.g1[7]) |-> ##3 wake_sts[0][7]
  ) else $error("group one pin 7 did not reach status bit 7");

  a_map_ring_one: assert property (                               // see RULE7
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(wake_src_i.ring[0]) |-> ##3 wake_sts[1][0]
  ) else $error("ring one did not reach group two bit 0");

  a_map_ring_two: assert property (                               // see RULE7
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(wake_src_i.ring[1]) |-> ##3 wake_sts[1][1]
  ) else $error("ring two did not reach group two bit 1");

  a_map_g2_low: assert property (                                 // see RULE7
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(wake_src_i.g2[0]) |-> ##3 wake_sts[1][2]
  ) else $error("group two pin 0 did not reach status bit 2");

  a_map_g2_high: assert property (                                // see RULE7
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(wake_src_i.g2[4]) |-> ##3 wake_sts[1][6]
  ) else $error("group two pin 4 did not reach status bit 6");

  a_map_g3_low: assert property (                                 // see RULE8
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(wake_src_i.g3[0]) |-> ##3 wake_sts[2][0]
  ) else $error("group three pin 0 did not reach status bit 0");

  a_map_g3_high: assert property (                                // see RULE8
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(wake_src_i.g3[7]) |-> ##3 wake_sts[2][7]
  ) else $error("group three pin 7 did not reach status bit 7");

  a_oe_follows_state: assert property (                           // see RULE1
    @(posedge clk_i) disable iff (!rst_b_i)
    wake_event_oe_o == (glob_en && glob_sts)
  ) else $error("wake output drive differs from enable and status");

  a_enable_bit_write: assert property (                           // see RULE2
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_glob_en |=> (glob_en == $past(reg_req_i.wdata[GLOB_BIT]))
  ) else $error("global enable did not take written bit 0");

  a_enable_kept: assert property (                                // see RULE3
    @(posedge clk_i) disable iff (!rst_b_i)
    !wr_glob_en |=> $stable(glob_en)
  ) else $error("global enable changed without a write");

  a_status_kept: assert property (                                // see RULE9
    @(posedge clk_i) disable iff (!rst_b_i)
    (!reg_req_i.wr_en && evt_vec[G2_INDEX*DATA_W +: DATA_W] == ALL_ZERO) |=>
      $stable(wake_sts[G2_INDEX])
  ) else $error("group two status changed with no event or write");

  a_g2_read_rsvd: assert property (                               // see RULE14
    @(posedge clk_i) disable iff (!rst_b_i)
    (reg_req_i.rd_en && reg_req_i.addr == OFF_STS_G2) |=> !rd_data_o[DATA_W-1]
  ) else $error("group two reserved bit read nonzero");

  a_unmapped_reads_zero: assert property (                        // see RULE14
    @(posedge clk_i) disable iff (!rst_b_i)
    (reg_req_i.rd_en && reg_req_i.addr > OFF_STS_G3) |=> (rd_data_o == ALL_ZERO)
  ) else $error("unmapped offset read nonzero");

  a_global_sticky: assert property (                              // see RULE13
    @(posedge clk_i) disable iff (!rst_b_i)
    (glob_sts && !(wr_glob_sts && reg_req_i.wdata[GLOB_BIT])) |=> glob_sts
  ) else $error("global status dropped without a written one");

  a_global_needs_source: assert property (                        // see RULE12
    @(posedge clk_i) disable iff (!rst_b_i)
    (!glob_sts && !pending) |=> !glob_sts
  ) else $error("global status set with no enabled pending source");

  a_read_g1_data: assert property (                               // see RULE6
    @(posedge clk_i) disable iff (!rst_b_i)
    (reg_req_i.rd_en && reg_req_i.addr == OFF_STS_G1) |=> (rd_data_o == $past(wake_sts[0]))
  ) else $error("group one read data differs from status");

endmodule : wes_wake_status_bank

`default_nettype wire
